/* File: csb_ext_model.sv */
// Peripheral and core register model answering forwarded accesses
module csb_ext_model
  import csb_pkg::*;
(
  input  wire logic        clk_sys,  // Core clock
  input  wire csb_ext_type ext_port, // Forwarded access
  output logic [7:0]       ext_rdata // Read data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] regs [0:31];
  logic [7:0] last = 8'h00;
  // Idle bus shows the inverse of the last value, so stale data cannot match
  assign ext_rdata = ext_port.sel ? regs[ext_port.addr[4:0]] : ~last;
  always @(posedge clk_sys) begin
    if (ext_port.sel && ext_port.write) regs[ext_port.addr[4:0]] <= ext_port.wdata;
    last <= ext_rdata;
  end
endmodule : csb_ext_model

/* File: csb_pkg.sv */
// Constants and types for the CPU status register and banked data memory
package csb_pkg;

  // ----------------------------------------------------------------------
  // Address layout
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W           = 12;
  localparam int unsigned BANK_W           = 5;
  localparam int unsigned OFS_W            = 7;
  localparam logic [6:0]  STATUS_OFS       = 7'h03;
  localparam logic [6:0]  PERIPH_FIRST_OFS = 7'h0c;
  localparam logic [6:0]  GPR_FIRST_OFS    = 7'h20;
  localparam logic [6:0]  COMMON_FIRST_OFS = 7'h70;
  localparam logic [11:0] GPR_BANK_BYTES   = 12'h050;
  localparam logic [4:0]  GPR_BANKS        = 5'h08;
  localparam logic [11:0] GPR_TOTAL        = 12'h280;
  localparam int unsigned GPR_DEPTH        = 640;
  localparam int unsigned COMMON_DEPTH     = 16;

  // ----------------------------------------------------------------------
  // Status register fields and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned STAT_C_BIT           = 0;
  localparam int unsigned STAT_DIGIT_CARRY_BIT = 1;
  localparam int unsigned STAT_Z_BIT           = 2;
  localparam int unsigned STAT_POWER_DOWN_BIT  = 3;
  localparam int unsigned STAT_WDT_TIMEOUT_BIT = 4;
  localparam logic        STAT_WDT_TIMEOUT_RST = 1'b1;
  localparam logic        STAT_POWER_DOWN_RST  = 1'b1;
  localparam logic        STAT_ALU_RST         = 1'b0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE, OP_LOGIC, OP_ADD, OP_SUB, OP_ROT_RIGHT, OP_ROT_LEFT, OP_CLEAR
  } csb_op_type;

  typedef enum logic [2:0] {
    AREA_UNIMP, AREA_STATUS, AREA_EXT, AREA_GPR, AREA_COMMON
  } csb_area_type;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        linear;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } csb_mem_req_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
  } csb_mem_rsp_type;

  typedef struct packed {
    logic        valid;
    csb_op_type  op;
    logic [7:0]  a;
    logic [7:0]  b;
  } csb_exec_type;

  typedef struct packed {
    logic [7:0] result;
    logic       z;
    logic       digit_carry_flag;
    logic       c;
    logic       upd_z;
    logic       upd_digit_carry;
    logic       upd_c;
  } csb_alu_out_type;

  typedef struct packed {
    csb_area_type area;
    logic [11:0]  idx;
  } csb_dec_type;

  typedef struct packed {
    logic        sel;
    logic        write;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } csb_ext_type;

endpackage : csb_pkg

/* File: csb_status_mem.sv */
// CPU status register, ALU flag logic and banked data memory
//
// What this block does
// - Status-destination writes keep operation flag results for flags the operation updates.
// - Instruction writes never change the watchdog time-out or power-down flags.
// - Clear aimed at status gives 000u u1uu: zero set, others kept.
// - Status bits 7 to 5 always read as zero.
// - Time-out flag set by power-up, watchdog clear, sleep; cleared on time-out.
// - Power-down flag set by power-up or watchdog clear; cleared by sleep.
// - Zero flag set when a logic, add, subtract or clear result is zero, cleared otherwise.
// - Digit carry reflects carry out of the low nibble on add and subtract.
// - Carry reflects carry out of bit 7 on add and subtract.
// - Subtraction adds the two's complement, so carries are inverted borrows.
// - Rotates through carry load carry with the bit shifted out.
// - Power-on reset: cause flags one, ALU flags zero; later events update.
// - Offsets 0ch to 1fh of each bank go to peripheral registers.
// - Each implemented bank holds 80 general RAM bytes after the peripheral area.
// - Sixteen common bytes appear at 70h to 7fh of every bank.
// - Linear access reaches all general RAM as one contiguous region.
// - Twelve-bit addresses: upper five bits bank, lower seven bits offset.
// - First twelve offsets of each bank are core registers, status at 03h.
// - Unimplemented locations read as zero.
module csb_status_mem
  import csb_pkg::*;
(
  input  wire logic            clk_sys,       // Core clock, 100 MHz
  input  wire logic            rst_n,         // Power-on or brown-out reset
  input  wire csb_mem_req_type mem_req,       // Data memory access
  output csb_mem_rsp_type      mem_rsp,       // Read data, one cycle later
  output csb_ext_type          ext_port,      // Core and peripheral forward
  input  wire logic [7:0]      ext_rdata,     // Data from forwarded location
  input  wire csb_exec_type    exec,          // Operation issued to the ALU
  output logic [7:0]           alu_result,    // Registered operation result
  output logic                 alu_valid,     // Result strobe
  input  wire logic            wdt_clear_evt, // Watchdog clear executed
  input  wire logic            sleep_evt,     // Sleep executed
  input  wire logic            wdt_timeout_evt, // Watchdog expired
  output logic [7:0]           cpu_flags      // Live status register value
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                             watchdog_timeout_flag_n;
    logic                             power_down_flag_n;
    logic                             z;
    logic                             digit_carry_flag;
    logic                             c;
    logic [GPR_DEPTH-1:0][7:0]        general_purpose_ram;
    logic [COMMON_DEPTH-1:0][7:0]     common;
    logic                             rsp_valid;
    logic [7:0]                       rsp_data;
    logic [7:0]                       alu_res;
    logic                             alu_vld;
  } csb_state_type;

  csb_state_type state;
  csb_state_type next_state;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic csb_dec_type decode(input csb_mem_req_type req);
    csb_dec_type d;
    logic [4:0]  bank;
    logic [6:0]  ofs;
    d    = '{area: AREA_UNIMP, idx: 12'h000};
    bank = req.addr[ADDR_W-1:OFS_W];
    ofs  = req.addr[OFS_W-1:0];
    if (req.linear) begin
      if (req.addr < GPR_TOTAL) begin
        d.area = AREA_GPR;
        d.idx  = req.addr;
      end
    end else if (ofs < PERIPH_FIRST_OFS) begin
      d.area = (ofs == STATUS_OFS) ? AREA_STATUS : AREA_EXT;
    end else if (ofs < GPR_FIRST_OFS) begin
      d.area = AREA_EXT;
    end else if (ofs < COMMON_FIRST_OFS) begin
      if (bank < GPR_BANKS) begin
        d.area = AREA_GPR;
        d.idx  = 12'(bank) * GPR_BANK_BYTES + 12'(ofs) - 12'(GPR_FIRST_OFS);
      end
    end else begin
      d.area = AREA_COMMON;
      d.idx  = {8'h00, ofs[3:0]};
    end
    return d;
  endfunction : decode

  // ----------------------------------------------------------------------
  // ALU flag computation
  // ----------------------------------------------------------------------
  function automatic csb_alu_out_type alu_flags(input csb_exec_type ex,
                                                 input logic c_in);
    csb_alu_out_type o;
    logic [7:0]      bx;
    logic            cin;
    logic [8:0]      sum;
    logic [4:0]      nib;
    o   = '0;
    // Subtract is add of the complement plus one: carries act as not-borrow
    bx  = (ex.op == OP_SUB) ? ~ex.b : ex.b;
    cin = (ex.op == OP_SUB);
    sum = {1'b0, ex.a} + {1'b0, bx} + {8'h00, cin};
    nib = {1'b0, ex.a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
    unique case (ex.op)
      OP_NONE: begin
        o.result = ex.a;
      end
      OP_LOGIC: begin
        o.result = ex.a;
        o.upd_z  = 1'b1;
      end
      OP_ADD, OP_SUB: begin
        o.result = sum[7:0];
        o.upd_z  = 1'b1;
        o.upd_digit_carry  = 1'b1;
        o.upd_c            = 1'b1;
        o.digit_carry_flag = nib[4];
        o.c      = sum[8];
      end
      OP_ROT_RIGHT: begin
        o.result = {c_in, ex.a[7:1]};
        o.upd_c  = 1'b1;
        o.c      = ex.a[0];
      end
      OP_ROT_LEFT: begin
        o.result = {ex.a[6:0], c_in};
        o.upd_c  = 1'b1;
        o.c      = ex.a[7];
      end
      OP_CLEAR: begin
        o.result = 8'h00;
        o.upd_z  = 1'b1;
      end
      default: begin
        o.result = ex.a;
      end
    endcase
    o.z = (o.result == 8'h00);
    return o;
  endfunction : alu_flags

  // ----------------------------------------------------------------------
  // Status image
  // ----------------------------------------------------------------------
  function automatic logic [7:0] status_image(input csb_state_type s);
    logic [7:0] v;
    v              = 8'h00;
    v[STAT_WDT_TIMEOUT_BIT] = s.watchdog_timeout_flag_n;
    v[STAT_POWER_DOWN_BIT]  = s.power_down_flag_n;
    v[STAT_Z_BIT]           = s.z;
    v[STAT_DIGIT_CARRY_BIT] = s.digit_carry_flag;
    v[STAT_C_BIT]           = s.c;
    return v;
  endfunction : status_image

  // ----------------------------------------------------------------------
  // Combinational next state
  // ----------------------------------------------------------------------
  csb_dec_type     dec;
  csb_alu_out_type alu;
  logic            wr_status;

  always_comb begin
    dec        = decode(mem_req);
    alu        = alu_flags(exec, state.c);
    wr_status  = mem_req.valid && mem_req.write && (dec.area == AREA_STATUS);
    next_state = state;

    // Read path: data registered, answer one cycle after the request
    next_state.rsp_valid = mem_req.valid && !mem_req.write;
    next_state.rsp_data  = 8'h00;
    if (mem_req.valid && !mem_req.write) begin
      unique case (dec.area)
        AREA_STATUS: next_state.rsp_data = status_image(state);
        AREA_EXT:    next_state.rsp_data = ext_rdata;
        AREA_GPR:    next_state.rsp_data = state.general_purpose_ram[dec.idx];
        AREA_COMMON: next_state.rsp_data = state.common[dec.idx[3:0]];
        AREA_UNIMP:  next_state.rsp_data = 8'h00;
      endcase
    end

    // Write path to local storage; unmapped writes simply drop
    if (mem_req.valid && mem_req.write) begin
      unique case (dec.area)
        AREA_GPR:    next_state.general_purpose_ram[dec.idx] = mem_req.wdata;
        AREA_COMMON: next_state.common[dec.idx[3:0]] = mem_req.wdata;
        default:     ;
      endcase
    end

    // Instruction write to status: only the three ALU flags take data;
    // bits 7..3 are dropped, so the reset-cause flags stay put
    if (wr_status) begin
      next_state.z = mem_req.wdata[STAT_Z_BIT];
      // A clear aimed at status only sets zero; both carries stay put
      if (!(exec.valid && exec.op == OP_CLEAR)) begin
        next_state.digit_carry_flag = mem_req.wdata[STAT_DIGIT_CARRY_BIT];
        next_state.c                = mem_req.wdata[STAT_C_BIT];
      end
    end

    // Flag results override the written value for flags the op updates
    if (exec.valid) begin
      if (alu.upd_z) begin
        next_state.z = alu.z;
      end
      if (alu.upd_digit_carry) begin
        next_state.digit_carry_flag = alu.digit_carry_flag;
      end
      if (alu.upd_c) begin
        next_state.c = alu.c;
      end
    end

    // Reset-cause flags move only on hardware events; time-out is last
    // so a simultaneous clear cannot hide an expiry
    if (wdt_clear_evt) begin
      next_state.watchdog_timeout_flag_n = 1'b1;
      next_state.power_down_flag_n       = 1'b1;
    end
    if (sleep_evt) begin
      next_state.watchdog_timeout_flag_n = 1'b1;
      next_state.power_down_flag_n       = 1'b0;
    end
    if (wdt_timeout_evt) begin
      next_state.watchdog_timeout_flag_n = 1'b0;
    end

    next_state.alu_res = alu.result;
    next_state.alu_vld = exec.valid;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state      <= '0;
      state.watchdog_timeout_flag_n <= STAT_WDT_TIMEOUT_RST;
      state.power_down_flag_n       <= STAT_POWER_DOWN_RST;
      state.z                       <= STAT_ALU_RST;
      state.digit_carry_flag        <= STAT_ALU_RST;
      state.c    <= STAT_ALU_RST;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Forward is combinational so the owner can answer in the same cycle
  always_comb begin
    ext_port.sel   = mem_req.valid && (dec.area == AREA_EXT);
    ext_port.write = mem_req.write;
    ext_port.addr  = mem_req.addr;
    ext_port.wdata = mem_req.wdata;
  end

  assign mem_rsp.valid = state.rsp_valid;
  assign mem_rsp.rdata = state.rsp_data;
  assign alu_result    = state.alu_res;
  assign alu_valid     = state.alu_vld;
  assign cpu_flags     = status_image(state);

endmodule : csb_status_mem

/* File: csb_status_mem_assertions.sv */
// Checker for the status flags and memory decode of the status block
module csb_status_mem_assertions
  import csb_pkg::*;
(
  input wire logic            clk_sys,         // Core clock
  input wire logic            rst_n,           // Reset
  input wire csb_mem_req_type mem_req,         // Memory request
  input wire csb_mem_rsp_type mem_rsp,         // Memory answer
  input wire csb_ext_type     ext_port,        // Forwarded access
  input wire logic [7:0]      ext_rdata,       // Forwarded data
  input wire csb_exec_type    exec,            // Operation
  input wire logic [7:0]      alu_result,      // Result
  input wire logic            alu_valid,       // Result strobe
  input wire logic            wdt_clear_evt,   // Watchdog clear
  input wire logic            sleep_evt,       // Sleep
  input wire logic            wdt_timeout_evt, // Time-out
  input wire logic [7:0]      cpu_flags        // Status image
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] s_add, s_sub;
  logic [4:0] n_add, n_sub;
  logic [2:0] add_f, sub_f;
  logic       rot_out, a_zero;
  // Reference sums kept apart from the design's adder
  assign s_add = {1'b0, exec.a} + {1'b0, exec.b};
  assign s_sub = {1'b0, exec.a} + {1'b0, ~exec.b} + 9'h001;
  assign n_add = {1'b0, exec.a[3:0]} + {1'b0, exec.b[3:0]};
  assign n_sub = {1'b0, exec.a[3:0]} + {1'b0, ~exec.b[3:0]} + 5'h01;
  assign add_f = {s_add[7:0] == 8'h00, n_add[4], s_add[8]};
  assign sub_f = {s_sub[7:0] == 8'h00, n_sub[4], s_sub[8]};
  assign rot_out = (exec.op == OP_ROT_RIGHT) ? exec.a[0] : exec.a[7];
  assign a_zero = (exec.a == 8'h00);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_upper_zero: assert property (cpu_flags[7:5] == 3'h0)
    else $error("upper status bits not zero");
  chk_add_flags: assert property (exec.valid && exec.op == OP_ADD
    |=> cpu_flags[2:0] == $past(add_f)) else $error("add flags wrong");
  chk_sub_flags: assert property (exec.valid && exec.op == OP_SUB
    |=> cpu_flags[2:0] == $past(sub_f)) else $error("subtract flags wrong");
  chk_rot_carry: assert property (exec.valid && exec.op inside {OP_ROT_RIGHT, OP_ROT_LEFT}
    |=> cpu_flags[0] == $past(rot_out)) else $error("rotate carry wrong");
  chk_zero_logic: assert property (exec.valid && exec.op == OP_LOGIC
    |=> cpu_flags[2] == $past(a_zero)) else $error("zero flag wrong");
  chk_timeout_low: assert property (wdt_timeout_evt |=> !cpu_flags[4])
    else $error("time-out flag not cleared");
  chk_sleep_pd: assert property (sleep_evt |=> !cpu_flags[3])
    else $error("power-down flag not cleared");
  chk_cause_hold: assert property (!(wdt_timeout_evt || wdt_clear_evt || sleep_evt)
    |=> $stable(cpu_flags[4:3])) else $error("reset-cause flags moved");
  chk_periph_fwd: assert property (mem_req.valid && !mem_req.linear
    && mem_req.addr[6:0] >= PERIPH_FIRST_OFS && mem_req.addr[6:0] < GPR_FIRST_OFS
    |-> ext_port.sel) else $error("peripheral access not forwarded");
  chk_clear_keep: assert property (exec.valid && exec.op == OP_CLEAR
    |=> cpu_flags[2] && cpu_flags[1:0] == $past(cpu_flags[1:0]))
    else $error("clear changed the carry flags");
  chk_alu_strobe: assert property (exec.valid |=> alu_valid)
    else $error("result strobe missing");
endmodule : csb_status_mem_assertions

bind csb_status_mem csb_status_mem_assertions u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .mem_req(mem_req), .mem_rsp(mem_rsp), .ext_port(ext_port), .ext_rdata(ext_rdata),
  .exec(exec), .alu_result(alu_result), .alu_valid(alu_valid), .wdt_clear_evt(wdt_clear_evt),
  .sleep_evt(sleep_evt), .wdt_timeout_evt(wdt_timeout_evt), .cpu_flags(cpu_flags));

/* File: csb_status_mem_tb.sv */
// Self-checking testbench of the status register and banked memory
module csb_status_mem_tb
  import csb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic            clk_sys = 1'b0;
  logic            rst_n = 1'b0;
  csb_mem_req_type mem_req = '0;
  csb_exec_type    exec = '0;
  logic            wdt_clear_evt = 1'b0, sleep_evt = 1'b0, wdt_timeout_evt = 1'b0;
  csb_mem_rsp_type mem_rsp;
  csb_ext_type     ext_port;
  logic [7:0]      ext_rdata, alu_result, cpu_flags, flg, rd, v;
  logic            alu_valid;
  logic            c_before;
  logic [15:0]     e;
  int              bad_count = 0;
  int              check_count = 0;
  always #5 clk_sys = ~clk_sys;
  csb_status_mem dut (.clk_sys(clk_sys), .rst_n(rst_n), .mem_req(mem_req), .mem_rsp(mem_rsp),
    .ext_port(ext_port), .ext_rdata(ext_rdata), .exec(exec), .alu_result(alu_result),
    .alu_valid(alu_valid), .wdt_clear_evt(wdt_clear_evt), .sleep_evt(sleep_evt),
    .wdt_timeout_evt(wdt_timeout_evt), .cpu_flags(cpu_flags));
  csb_ext_model u_ext (.clk_sys(clk_sys), .ext_port(ext_port), .ext_rdata(ext_rdata));
  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  task cmp(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task wr(input logic lin, input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    mem_req = '{1'b1, 1'b1, lin, a, d};
    @(negedge clk_sys);
    mem_req.valid = 1'b0;
  endtask : wr
  task rdm(input logic lin, input logic [11:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    mem_req = '{1'b1, 1'b0, lin, a, 8'h00};
    @(negedge clk_sys);
    mem_req.valid = 1'b0;
    d = (mem_rsp.valid === 1'b1) ? mem_rsp.rdata : 8'hxx;
  endtask : rdm
  function automatic logic [15:0] alu_exp(csb_op_type op, logic [7:0] a, b, f, logic ci);
    logic [8:0] s;
    logic [4:0] n;
    logic [7:0] r, bb, g;
    g = f;
    bb = (op == OP_SUB) ? ~b : b;
    s = {1'b0, a} + {1'b0, bb} + {8'h00, op == OP_SUB};
    n = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, op == OP_SUB};
    r = (op == OP_CLEAR) ? 8'h00 : a;
    if (op == OP_ADD || op == OP_SUB) begin
      r = s[7:0];
      g[1:0] = {n[4], s[8]};
    end
    if (op == OP_ROT_RIGHT) begin
      r = {ci, a[7:1]};
      g[0] = a[0];
    end
    if (op == OP_ROT_LEFT) begin
      r = {a[6:0], ci};
      g[0] = a[7];
    end
    if (op inside {OP_LOGIC, OP_ADD, OP_SUB, OP_CLEAR}) g[2] = (r == 8'h00);
    return {r, g};
  endfunction : alu_exp
  // Operation, optionally with a write aimed at the status register
  task step(input csb_op_type op, input logic [7:0] a, b, input logic w, input logic [7:0] d);
    // Rotates take the carry held before this cycle's status write
    c_before = flg[0];
    if (w && op != OP_CLEAR) flg = {3'h0, flg[4:3], d[2:0]};
    e = alu_exp(op, a, b, flg, c_before);
    flg = e[7:0];
    @(negedge clk_sys);
    exec = '{1'b1, op, a, b};
    mem_req = '{w, 1'b1, 1'b0, 12'h003, d};
    @(negedge clk_sys);
    exec.valid = 1'b0;
    mem_req.valid = 1'b0;
    if (op != OP_NONE) cmp(alu_result, e[15:8]);
    cmp({7'h00, alu_valid}, 8'h01);
    cmp(cpu_flags, flg);
  endtask : step
  // Pulses in order {time-out, watchdog clear, sleep}
  task ev(input logic [2:0] p);
    if (p[1]) flg[4:3] = 2'b11;
    if (p[0]) flg[4:3] = 2'b10;
    if (p[2]) flg[4] = 1'b0;
    @(negedge clk_sys);
    {wdt_timeout_evt, wdt_clear_evt, sleep_evt} = p;
    @(negedge clk_sys);
    {wdt_timeout_evt, wdt_clear_evt, sleep_evt} = 3'h0;
    cmp(cpu_flags, flg);
  endtask : ev
  // --------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------
  initial begin
    #100000;
    bad_count++;
    end_sim();
  end
  initial begin
    void'($urandom(75));
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    flg = 8'h18;
    cmp(cpu_flags, 8'h18);
    rdm(1'b0, 12'h003, rd);
    cmp(rd, 8'h18);
    rdm(1'b0, 12'h283, rd);
    cmp(rd, 8'h18);
    step(OP_NONE, 8'h00, 8'h00, 1'b1, 8'hff);
    step(OP_ADD, 8'h0f, 8'h01, 1'b1, 8'h07);
    step(OP_SUB, 8'h00, 8'h01, 1'b0, 8'h00);
    step(OP_ADD, 8'hff, 8'h01, 1'b0, 8'h00);
    step(OP_NONE, 8'h00, 8'h00, 1'b1, 8'h01);
    step(OP_CLEAR, 8'h00, 8'h00, 1'b1, 8'h00);
    for (int i = 0; i < 60; i++) begin
      step(csb_op_type'(3'($urandom_range(1, 5))), 8'($urandom), 8'($urandom),
           1'($urandom), 8'($urandom));
    end
    ev(3'b100);
    ev(3'b010);
    ev(3'b001);
    ev(3'b011);
    ev(3'b101);
    ev(3'b010);
    v = 8'($urandom);
    wr(1'b0, 12'h070, v);
    rdm(1'b0, 12'h5f0, rd);
    cmp(rd, v);
    wr(1'b0, 12'h120, v + 8'h01);
    rdm(1'b1, 12'h0a0, rd);
    cmp(rd, v + 8'h01);
    wr(1'b1, 12'h27f, ~v);
    rdm(1'b0, 12'h3ef, rd);
    cmp(rd, ~v);
    wr(1'b0, 12'h420, v);
    rdm(1'b0, 12'h420, rd);
    cmp(rd, 8'h00);
    rdm(1'b1, 12'h280, rd);
    cmp(rd, 8'h00);
    wr(1'b0, 12'h10c, v);
    rdm(1'b0, 12'h10c, rd);
    cmp(rd, v);
    wr(1'b0, 12'h009, ~v);
    rdm(1'b0, 12'h089, rd);
    cmp(rd, ~v);
    step(OP_ADD, 8'h08, 8'h08, 1'b0, 8'h00);
    rst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    cmp(cpu_flags, 8'h18);
    rst_n = 1'b1;
    rdm(1'b0, 12'h003, rd);
    cmp(rd, 8'h18);
    end_sim();
  end
endmodule : csb_status_mem_tb
